// ---- include/mhbm_pkg.sv ----
// Purpose: Shared constants and types for the microcontroller-style host bus master
// Assumes: One core clock at 40 MHz, asynchronous active-low reset
// Notes: Command codes and timing counts live here only
// Summary of operation
// - Both channels' pins combine into one microcontroller-style host bus master.
// - Low address and data share one bidirectional eight-bit bus, bits 7:0.
// - Address bits 15:8 go out on eight separate output-only lines.
// - Active-low select stays asserted throughout each read or write cycle.
// - A high pulse on the latch strobe lets peripherals capture the address.
// - A read cycle is signalled by driving the read strobe low.
// - Write data is driven before write strobe falls and held past its rise.
// - A low ready input stretches the current cycle for as long as it stays low.
// - The master clock pin outputs the core clock divided by two.
// - Host commands set, clear or read both auxiliary pins as general I/O.
// - Wait commands stall execution until auxiliary pin 1 is high, or low.
// - Pin 1 as interrupt: wait for it, then bus read, return value to host.
package mhbm_pkg;
  localparam int CORE_CLK_HZ = 40000000;
  // Least strobe low time in ns, rounded up to whole cycles
  localparam int STRB_MIN_NS = 75;
  localparam int STRB_CYC = (STRB_MIN_NS * (CORE_CLK_HZ / 1000000) + 999) / 1000;
  localparam logic [2:0] STRB_CNT = 3'(STRB_CYC - 1);
  localparam logic [2:0] OP_RD = 3'h0;
  localparam logic [2:0] OP_WR = 3'h1;
  localparam logic [2:0] OP_SET_AUX = 3'h2;
  localparam logic [2:0] OP_RD_AUX = 3'h3;
  localparam logic [2:0] OP_WAIT_HI = 3'h4;
  localparam logic [2:0] OP_WAIT_LO = 3'h5;
  // Fields of the data byte for the auxiliary set command
  localparam int AUX_VAL_LSB = 0;
  localparam int AUX_DIR_LSB = 2;
  localparam logic [1:0] AUX_RST = 2'h0;
  localparam logic [7:0] DATA_RST = 8'h00;
  localparam logic [15:0] ADDR_RST = 16'h0000;

  typedef struct packed {
    logic [2:0] op;
    logic [15:0] addr;
    logic [7:0] data;
  } mhbm_cmd_t;

  typedef enum logic [5:0] {
    ST_IDLE = 6'b000001,
    ST_ADDR = 6'b000010,
    ST_TURN = 6'b000100,
    ST_STRB = 6'b001000,
    ST_HOLD = 6'b010000,
    ST_WAIT = 6'b100000
  } mhbm_state_t;
endpackage : mhbm_pkg

// ---- core/mhbm_sync.sv ----
// Purpose: Two-flop synchroniser for pin inputs
// Assumes: Inputs are asynchronous to core_clk_i
// Notes: The first stage feeds only the second
`timescale 1ns/100ps
module mhbm_sync #(
  parameter int W = 1
) (
  input wire logic core_clk_i,
  input wire logic nrst_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] meta;

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      meta <= '0;
      q_o <= '0;
    end else begin
      meta <= d_i;
      q_o <= meta;
    end
  end
endmodule : mhbm_sync

// ---- core/mhbm_master.sv ----
// Purpose: Microcontroller-style multiplexed host bus master driven by host commands
// Assumes: Commands arrive on core_clk_i; peripheral pins are asynchronous
// Notes: Read data is sampled through the pin synchroniser at the end of the strobe
`timescale 1ns/100ps
module mhbm_master (
  input wire logic core_clk_i,
  input wire logic nrst_i,
  input wire logic cmd_valid_i,
  input wire mhbm_pkg::mhbm_cmd_t cmd_i,
  output logic cmd_ready_o,
  output logic rsp_valid_o,
  output logic [7:0] rsp_data_o,
  input wire logic [7:0] shared_addr_data_bus_i,
  output logic [7:0] shared_addr_data_bus_o,
  output logic shared_addr_data_bus_oe_o,
  output logic [7:0] addr_hi_o,
  output logic sel_n_o,
  output logic ale_o,
  output logic rd_n_o,
  output logic wr_n_o,
  input wire logic cycle_ready_in_i,
  output logic master_clock_out_o,
  input wire logic [1:0] aux_pin_i,
  output logic [1:0] aux_pin_o,
  output logic [1:0] aux_pin_oe_o
);
  import mhbm_pkg::*;

  mhbm_state_t st;
  mhbm_state_t next_st;
  mhbm_cmd_t cur;
  logic [2:0] cnt;
  logic [7:0] bus_s;
  logic [1:0] aux_s;
  logic rdy_s;
  logic clk_div;

  wire take = cmd_valid_i && cmd_ready_o;
  wire is_wr = (cur.op == OP_WR);
  wire in_cycle = (st == ST_ADDR) || (st == ST_TURN) || (st == ST_STRB) || (st == ST_HOLD);
  wire strb_done = (cnt == 3'h0) && rdy_s;
  wire want_hi = (cur.op == OP_WAIT_HI);
  wire level_met = (aux_s[1] == want_hi);

  // Pins pass two flops before any logic reads them
  mhbm_sync #(.W(11)) u_sync (
    .core_clk_i(core_clk_i),
    .nrst_i(nrst_i),
    .d_i({cycle_ready_in_i, aux_pin_i, shared_addr_data_bus_i}),
    .q_o({rdy_s, aux_s, bus_s})
  );

  assign cmd_ready_o = (st == ST_IDLE);
  assign shared_addr_data_bus_o = (st == ST_ADDR) ? cur.addr[7:0] : cur.data;
  assign shared_addr_data_bus_oe_o = (st == ST_ADDR) || (is_wr && in_cycle && (st != ST_ADDR));
  assign addr_hi_o = cur.addr[15:8];
  assign sel_n_o = !in_cycle;
  assign ale_o = (st == ST_ADDR);
  assign rd_n_o = !((st == ST_STRB) && !is_wr);
  assign wr_n_o = !((st == ST_STRB) && is_wr);
  assign master_clock_out_o = clk_div;

  always_comb begin
    next_st = st;
    unique case (st)
      ST_IDLE: begin
        if (take && (cmd_i.op == OP_RD || cmd_i.op == OP_WR)) begin
          next_st = ST_ADDR;
        end else if (take && (cmd_i.op == OP_WAIT_HI || cmd_i.op == OP_WAIT_LO)) begin
          next_st = ST_WAIT;
        end
      end
      ST_ADDR: next_st = ST_TURN;
      ST_TURN: next_st = ST_STRB;
      ST_STRB: begin
        if (strb_done) begin
          next_st = ST_HOLD;
        end
      end
      ST_HOLD: next_st = ST_IDLE;
      ST_WAIT: begin
        if (level_met) begin
          next_st = ST_IDLE;
        end
      end
      default: next_st = ST_IDLE;
    endcase
  end

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st <= ST_IDLE;
      clk_div <= 1'b0;
    end else begin
      st <= next_st;
      clk_div <= !clk_div;
    end
  end

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cur <= '{op: OP_RD, addr: ADDR_RST, data: DATA_RST};
    end else if (take) begin
      cur <= cmd_i;
    end
  end

  // Strobe minimum width; ready is only honoured after it runs out
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cnt <= 3'h0;
    end else if (st == ST_TURN) begin
      cnt <= STRB_CNT;
    end else if (st == ST_STRB && cnt != 3'h0) begin
      cnt <= cnt - 3'h1;
    end
  end

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      aux_pin_o <= AUX_RST;
      aux_pin_oe_o <= AUX_RST;
    end else if (take && cmd_i.op == OP_SET_AUX) begin
      aux_pin_o <= cmd_i.data[AUX_VAL_LSB +: 2];
      aux_pin_oe_o <= cmd_i.data[AUX_DIR_LSB +: 2];
    end
  end

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rsp_valid_o <= 1'b0;
      rsp_data_o <= DATA_RST;
    end else begin
      rsp_valid_o <= 1'b0;
      if (st == ST_STRB && strb_done && !is_wr) begin
        rsp_valid_o <= 1'b1;
        rsp_data_o <= bus_s;
      end else if (take && cmd_i.op == OP_RD_AUX) begin
        rsp_valid_o <= 1'b1;
        rsp_data_o <= {6'h00, aux_s};
      end
    end
  end

  // Checks
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!nrst_i);

  sequence s_addr_phase;
    ale_o && shared_addr_data_bus_oe_o && !sel_n_o;
  endsequence

  sequence s_turn_quiet;
    !ale_o && rd_n_o && wr_n_o && !sel_n_o;
  endsequence

  property p_sel_cycle;
    $rose(ale_o) |-> !sel_n_o [*4];
  endproperty
  a_sel_cycle: assert property (p_sel_cycle) else $error("select released mid cycle");

  property p_ale_addr;
    ale_o |-> shared_addr_data_bus_oe_o && shared_addr_data_bus_o == cur.addr[7:0];
  endproperty
  a_ale_addr: assert property (p_ale_addr) else $error("address not on bus at latch");

  property p_hi_addr;
    take && cmd_i.op == OP_RD |=> addr_hi_o == $past(cmd_i.addr[15:8]);
  endproperty
  a_hi_addr: assert property (p_hi_addr) else $error("upper address wrong");

  property p_ale_pulse;
    $rose(ale_o) |=> !ale_o;
  endproperty
  a_ale_pulse: assert property (p_ale_pulse) else $error("latch pulse not one cycle");

  property p_rd_strobe;
    !rd_n_o |-> !shared_addr_data_bus_oe_o && !sel_n_o && wr_n_o;
  endproperty
  a_rd_strobe: assert property (p_rd_strobe) else $error("read strobe with bus driven");

  property p_wr_setup;
    $fell(wr_n_o) |-> $past(shared_addr_data_bus_oe_o) && $stable(shared_addr_data_bus_o);
  endproperty
  a_wr_setup: assert property (p_wr_setup) else $error("write data not set up");

  property p_wr_hold;
    $rose(wr_n_o) |-> shared_addr_data_bus_oe_o && $stable(shared_addr_data_bus_o);
  endproperty
  a_wr_hold: assert property (p_wr_hold) else $error("write data not held");

  property p_stretch;
    (st == ST_STRB) && !rdy_s |=> (st == ST_STRB);
  endproperty
  a_stretch: assert property (p_stretch) else $error("cycle ended while not ready");

  // The first edge out of reset still sees the reset level on both sides
  property p_clk_out;
    $past(nrst_i) |-> master_clock_out_o != $past(master_clock_out_o);
  endproperty
  a_clk_out: assert property (p_clk_out) else $error("master clock stalled");

  property p_aux_set;
    take && cmd_i.op == OP_SET_AUX |=> aux_pin_oe_o == $past(cmd_i.data[3:2]);
  endproperty
  a_aux_set: assert property (p_aux_set) else $error("aux direction not applied");

  property p_wait;
    (st == ST_WAIT) && !level_met |=> (st == ST_WAIT) && !cmd_ready_o;
  endproperty
  a_wait: assert property (p_wait) else $error("wait left before level");

  property p_rd_rsp;
    $rose(rd_n_o) |-> rsp_valid_o;
  endproperty
  a_rd_rsp: assert property (p_rd_rsp) else $error("read value not returned");

  property p_order;
    $rose(ale_o) |-> s_addr_phase ##1 s_turn_quiet;
  endproperty
  a_order: assert property (p_order) else $error("strobe too soon after latch");
endmodule : mhbm_master

// ---- tb/mhbm_periph.sv ----
// Purpose: Peripheral chip on the multiplexed bus
// Assumes: Address pins and strobes sampled on the core clock; write data on the write strobe edges
// Notes: A released bus shows the inverse of its last level
`timescale 1ns/100ps
module mhbm_periph (
  input wire logic clk_i,
  input wire logic [7:0] bus_i,
  input wire logic [7:0] addr_hi_i,
  input wire logic sel_n_i,
  input wire logic ale_i,
  input wire logic rd_n_i,
  input wire logic wr_n_i,
  input wire logic [3:0] stretch_i,
  output logic [7:0] bus_o,
  output logic ready_o
);
  logic [7:0] mem [256];
  logic [7:0] alat, ahi, wfall, wrise, last;
  logic [4:0] ale_w, rd_w;
  logic [3:0] hold = 4'h0;
  logic ale_q = 1'b0;
  logic rd_q = 1'b0;
  logic sel_bad = 1'b0;
  assign ready_o = (hold == 4'h0);
  assign bus_o = (!rd_n_i && !sel_n_i) ? mem[alat] : ~last;
  always @(posedge clk_i) begin
    last <= bus_i;
    hold <= ale_i ? stretch_i : (hold != 4'h0) ? hold - 4'h1 : hold;
    ale_q <= ale_i;
    rd_q <= !rd_n_i;
    if (ale_i) begin
      alat <= bus_i;
      ahi <= addr_hi_i;
      ale_w <= ale_q ? ale_w + 5'h1 : 5'h1;
    end
    if (!rd_n_i) begin
      rd_w <= rd_q ? rd_w + 5'h1 : 5'h1;
    end
    if ((ale_i || !rd_n_i || !wr_n_i) && sel_n_i) begin
      sel_bad <= 1'b1;
    end
  end
  always @(negedge wr_n_i) wfall = bus_i;
  always @(posedge wr_n_i) begin
    wrise = bus_i;
    mem[alat] = bus_i;
  end
endmodule : mhbm_periph

// ---- tb/mhbm_master_tb.sv ----
// Purpose: Self-checking bench for the host bus master
// Assumes: Peripheral model on the far side
// Notes: Commands raised only after ready is seen idle
`timescale 1ns/100ps
module mhbm_master_tb;
  import mhbm_pkg::*;
  logic clk, nrst, cmd_valid, cmd_ready, rsp_valid, bus_oe, sel_n, ale, rd_n, wr_n;
  logic ready, clk_out;
  mhbm_cmd_t cmd;
  logic [7:0] rsp_data, bus_o, bus_w, p_bus, addr_hi, d;
  logic [1:0] aux_o, aux_oe, aux_in, aux_w;
  logic [3:0] stretch;
  int err_count = 0;
  int comparisons = 0;
  assign bus_w = bus_oe ? bus_o : p_bus;
  assign aux_w = (aux_oe & aux_o) | (~aux_oe & aux_in);
  mhbm_master DUT (.core_clk_i(clk), .nrst_i(nrst), .cmd_valid_i(cmd_valid), .cmd_i(cmd),
    .cmd_ready_o(cmd_ready), .rsp_valid_o(rsp_valid), .rsp_data_o(rsp_data),
    .shared_addr_data_bus_i(bus_w), .shared_addr_data_bus_o(bus_o),
    .shared_addr_data_bus_oe_o(bus_oe), .addr_hi_o(addr_hi), .sel_n_o(sel_n), .ale_o(ale),
    .rd_n_o(rd_n), .wr_n_o(wr_n), .cycle_ready_in_i(ready), .master_clock_out_o(clk_out),
    .aux_pin_i(aux_w), .aux_pin_o(aux_o), .aux_pin_oe_o(aux_oe));
  mhbm_periph P (.clk_i(clk), .bus_i(bus_w), .addr_hi_i(addr_hi), .sel_n_i(sel_n),
    .ale_i(ale), .rd_n_i(rd_n), .wr_n_i(wr_n), .stretch_i(stretch), .bus_o(p_bus),
    .ready_o(ready));
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic issue(input logic [2:0] op, input logic [15:0] a, input logic [7:0] dt);
    int n = 0;
    @(negedge clk);
    while (cmd_ready !== 1'b1 && n < 60) begin
      n++;
      @(negedge clk);
    end
    chk("cmd_ready", 8'h01, {7'h0, cmd_ready});
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd <= '{op, a, dt};
    @(posedge clk);
    cmd_valid <= 1'b0;
  endtask : issue
  task automatic get_rsp(output logic [7:0] r);
    int n = 0;
    do begin
      n++;
      @(negedge clk);
    end while (rsp_valid !== 1'b1 && n < 60);
    r = rsp_data;
    chk("rsp_valid", 8'h01, {7'h0, rsp_valid});
  endtask : get_rsp
  task automatic t_clk();
    logic p;
    @(negedge clk);
    p = clk_out;
    repeat (4) begin
      @(negedge clk);
      chk("clk_out", {7'h0, ~p}, {7'h0, clk_out});
      p = clk_out;
    end
  endtask : t_clk
  task automatic t_write();
    issue(OP_WR, 16'h5a3c, 8'hc7);
    repeat (10) @(negedge clk);
    chk("addr_lo", 8'h3c, P.alat);
    chk("addr_hi", 8'h5a, P.ahi);
    chk("wr_setup", 8'hc7, P.wfall);
    chk("wr_hold", 8'hc7, P.wrise);
    chk("ale_width", 8'h01, {3'h0, P.ale_w});
    chk("sel_bad", 8'h00, {7'h0, P.sel_bad});
  endtask : t_write
  task automatic t_read(input logic [3:0] s, input logic [4:0] lo);
    stretch <= s;
    issue(OP_RD, 16'h5a3c, 8'h00);
    get_rsp(d);
    chk("rd_data", 8'hc7, d);
    chk("rd_long", 8'h01, {7'h0, P.rd_w >= lo});
  endtask : t_read
  task automatic t_aux();
    @(posedge clk);
    aux_in <= 2'b10;
    for (int i = 0; i < 2; i++) begin
      issue(OP_SET_AUX, 16'h0000, 8'h04 | 8'(i));
      // Pin readback lags the driven level by the two sync flops
      repeat (2) @(posedge clk);
      issue(OP_RD_AUX, 16'h0000, 8'h00);
      get_rsp(d);
      chk("aux_oe", 8'h01, {6'h0, aux_oe});
      chk("aux_rd", 8'h02 | 8'(i), d);
    end
  endtask : t_aux
  task automatic t_wait();
    @(posedge clk);
    // Pin 1 stays an input throughout
    aux_in <= 2'b00;
    issue(OP_WAIT_HI, 16'h0000, 8'h00);
    repeat (8) @(negedge clk);
    chk("wait_hi", 8'h00, {7'h0, cmd_ready});
    @(posedge clk);
    aux_in <= 2'b10;
    t_read(4'h0, 5'd3);
    issue(OP_WAIT_LO, 16'h0000, 8'h00);
    repeat (8) @(negedge clk);
    chk("wait_lo", 8'h00, {7'h0, cmd_ready});
    @(posedge clk);
    aux_in <= 2'b00;
    repeat (6) @(negedge clk);
    chk("wait_end", 8'h01, {7'h0, cmd_ready});
  endtask : t_wait
  task automatic tally_and_finish();
    if (err_count == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : tally_and_finish
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial begin
    #75000;
    err_count++;
    tally_and_finish();
  end
  initial begin
    nrst <= 1'b0;
    cmd_valid <= 1'b0;
    cmd <= '0;
    aux_in <= 2'b00;
    stretch <= 4'h0;
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    t_clk();
    t_write();
    t_read(4'h0, 5'd3);
    t_read(4'h6, 5'd7);
    t_aux();
    t_wait();
    tally_and_finish();
  end
endmodule : mhbm_master_tb
